// file: core/srts_limits.sv
/*
 * Per-type transfer limits: every-scan word count and multi-scan chunk size.
 * Assumes registered configuration inputs; purely combinational.
 */
`timescale 1ns/10ps
module srts_limits (
   input  wire logic [1:0]         mode,
   input  wire logic [7:0]         scans,
   input  wire srts_pkg::srts_cnt_t size    [4],
   input  wire srts_pkg::srts_cnt_t cust    [4],
   input  wire srts_pkg::srts_cnt_t extra   [4],
   output srts_pkg::srts_cnt_t      every_w [4],
   output srts_pkg::srts_cnt_t      chunk_w [4]
);
   srts_pkg::srts_cnt_t refs [4];
   srts_pkg::srts_cnt_t in_share, hd_share, in_lim, hd_lim;
   srts_pkg::srts_cnt_t div;

   // shares, spill-over and rounding of the default area
   always_comb begin
      in_share = srts_pkg::srts_min(size[2], srts_pkg::DEF_IN_SHARE);
      hd_share = srts_pkg::srts_min(size[3], srts_pkg::DEF_HOLD_SHARE);
      in_lim   = srts_pkg::DEF_IN_SHARE + (srts_pkg::DEF_HOLD_SHARE - hd_share);
      hd_lim   = srts_pkg::DEF_HOLD_SHARE + (srts_pkg::DEF_IN_SHARE - in_share);
      div      = (scans == 8'h00) ? 17'h00001 : {9'h000, scans};
      for (int t = 0; t < 4; t++) begin
         case (mode)
            srts_pkg::MODE_DEFAULT: begin
               if (t < 2) begin
                  refs[t] = srts_pkg::srts_min(size[t], srts_pkg::DEF_POINTS);
               end else if (t == 2) begin
                  refs[t] = srts_pkg::srts_min(size[t], in_lim);
               end else begin
                  refs[t] = (size[t] <= hd_lim) ? size[t]
                          : srts_pkg::srts_min(srts_pkg::srts_up16(hd_lim), size[t]);
               end
            end
            srts_pkg::MODE_WHOLE: refs[t] = size[t];
            default:              refs[t] = srts_pkg::srts_min(cust[t], size[t]);
         endcase
         every_w[t] = srts_pkg::srts_words(2'(t), refs[t]);
         chunk_w[t] = (mode == srts_pkg::MODE_MULTI)
                    ? srts_pkg::srts_words(2'(t), extra[t] / div) : 17'h00000;
      end
   end
endmodule

// file: core/srts_top.sv
/*
 * State RAM transfer scheduler: AHB-Lite register slave, per-scan sequencing of
 * state memory reads and streaming of the selected words to the peer module.
 * Assumes the controller pulses scan_start and answers each read with rd_valid.
 */
`timescale 1ns/10ps
module srts_top (
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic        ce,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        scan_start,
   output logic             rd_req,
   output logic [1:0]       rd_type,
   output logic [15:0]      rd_addr,
   input  wire logic        rd_valid,
   input  wire logic [15:0] rd_data,
   output logic             link_tx,
   output logic             busy,
   output logic             scan_done
);
   // configuration
   logic [1:0]          ctrl_mode;
   logic                ctrl_en;
   logic [7:0]          scans;
   logic [1:0]          hole_type;
   logic [15:0]         hole_start;
   srts_pkg::srts_cnt_t hole_len;
   srts_pkg::srts_cnt_t size    [4];
   srts_pkg::srts_cnt_t cust    [4];
   srts_pkg::srts_cnt_t extra   [4];
   srts_pkg::srts_cnt_t every_w [4];
   srts_pkg::srts_cnt_t chunk_w [4];
   srts_pkg::srts_cnt_t chunk_off [4];
   // sequencing
   srts_pkg::srts_state_e state;
   logic [2:0]          seg;
   srts_pkg::srts_cnt_t pos;
   srts_pkg::srts_cnt_t sent;
   srts_pkg::srts_cnt_t sent_last;
   logic [7:0]          scan_idx;
   logic [15:0]         word;
   logic                tx_valid;
   logic                tx_ready;
   // bus
   logic                ap_wr;
   logic [7:0]          ap_ofs;
   logic [31:0]         next_rdata;
   // segment view
   logic [1:0]          cur_t;
   srts_pkg::srts_cnt_t seg_len, seg_addr, size_w;
   logic                in_hole;
   logic [1:0]          last_type;

   srts_limits u_limits (
      .mode    (ctrl_mode),
      .scans   (scans),
      .size    (size),
      .cust    (cust),
      .extra   (extra),
      .every_w (every_w),
      .chunk_w (chunk_w)
   );

   srts_txser u_txser (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .ce       (ce),
      .tx_valid (tx_valid),
      .tx_word  (word),
      .tx_ready (tx_ready),
      .link_tx  (link_tx)
   );

   // read mux for the address phase
   always_comb begin
      next_rdata = 32'h00000000;
      if (haddr[31:8] == 24'h000000) begin
         case (haddr[7:4])
            srts_pkg::GRP_SIZE:  next_rdata = {15'h0000, size[haddr[3:2]]};
            srts_pkg::GRP_CUST:  next_rdata = {15'h0000, cust[haddr[3:2]]};
            srts_pkg::GRP_EXTRA: next_rdata = {15'h0000, extra[haddr[3:2]]};
            default: begin
               case (haddr[7:0])
                  srts_pkg::OFS_CTRL:       next_rdata = {29'h00000000, ctrl_en, ctrl_mode};
                  srts_pkg::OFS_SCANS:      next_rdata = {24'h000000, scans};
                  srts_pkg::OFS_HOLE_TYPE:  next_rdata = {30'h00000000, hole_type};
                  srts_pkg::OFS_HOLE_START: next_rdata = {16'h0000, hole_start};
                  srts_pkg::OFS_HOLE_LEN:   next_rdata = {15'h0000, hole_len};
                  srts_pkg::OFS_STATUS:     next_rdata = {20'h00000, scan_idx, seg, busy};
                  srts_pkg::OFS_SENT:       next_rdata = {15'h0000, sent_last};
                  default:                  next_rdata = 32'h00000000;
               endcase
            end
         endcase
      end
   end

   // ahb-lite slave: zero wait states, read data captured in the address phase
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ap_wr     <= 1'b0;
         ap_ofs    <= 8'h00;
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else if (ce) begin
         ap_wr <= 1'b0;
         if (hready && hsel && htrans[1]) begin
            ap_wr  <= hwrite && (haddr[31:8] == 24'h000000);
            ap_ofs <= haddr[7:0];
            if (!hwrite) begin
               hrdata <= next_rdata;
            end
         end
      end
   end

   // register writes in the data phase
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ctrl_mode  <= srts_pkg::MODE_DEFAULT;
         ctrl_en    <= 1'b0;
         scans      <= srts_pkg::RST_SCANS;
         hole_type  <= srts_pkg::TYPE_COIL;
         hole_start <= 16'h0000;
         hole_len   <= srts_pkg::RST_COUNT;
         for (int t = 0; t < 4; t++) begin
            size[t]  <= srts_pkg::RST_COUNT;
            cust[t]  <= srts_pkg::RST_COUNT;
            extra[t] <= srts_pkg::RST_COUNT;
         end
      end else if (ce && ap_wr) begin
         case (ap_ofs[7:4])
            srts_pkg::GRP_SIZE:  size[ap_ofs[3:2]]  <= hwdata[16:0];
            srts_pkg::GRP_CUST:  cust[ap_ofs[3:2]]  <= hwdata[16:0];
            srts_pkg::GRP_EXTRA: extra[ap_ofs[3:2]] <= hwdata[16:0];
            default: begin
               case (ap_ofs)
                  srts_pkg::OFS_CTRL: begin
                     ctrl_mode <= hwdata[srts_pkg::CTRL_MODE_LSB +: 2];
                     ctrl_en   <= hwdata[srts_pkg::CTRL_EN_BIT];
                  end
                  srts_pkg::OFS_SCANS:      scans      <= hwdata[7:0];
                  srts_pkg::OFS_HOLE_TYPE:  hole_type  <= hwdata[1:0];
                  srts_pkg::OFS_HOLE_START: hole_start <= hwdata[15:0];
                  srts_pkg::OFS_HOLE_LEN:   hole_len   <= hwdata[16:0];
                  default: ;
               endcase
            end
         endcase
      end
   end

   // current segment: even seg is the every-scan region, odd seg the extra chunk
   always_comb begin
      cur_t    = seg[2:1];
      seg_len  = seg[0] ? chunk_w[cur_t] : every_w[cur_t];
      seg_addr = (seg[0] ? every_w[cur_t] + chunk_off[cur_t] : 17'h00000) + pos;
      size_w   = srts_pkg::srts_words(cur_t, size[cur_t]);
      in_hole  = (hole_len != 17'h00000) && (cur_t == hole_type)
              && (seg_addr >= {1'b0, hole_start})
              && (seg_addr < ({1'b0, hole_start} + hole_len));
   end

   // per-scan sequencer
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state     <= srts_pkg::ST_IDLE;
         seg       <= 3'h0;
         pos       <= 17'h00000;
         sent      <= 17'h00000;
         sent_last <= 17'h00000;
         word      <= 16'h0000;
         rd_req    <= 1'b0;
         rd_type   <= 2'h0;
         rd_addr   <= 16'h0000;
         tx_valid  <= 1'b0;
         busy      <= 1'b0;
         scan_done <= 1'b0;
      end else if (ce) begin
         rd_req    <= 1'b0;
         tx_valid  <= 1'b0;
         scan_done <= 1'b0;
         case (state)
            srts_pkg::ST_IDLE: begin
               if (scan_start && ctrl_en) begin
                  busy  <= 1'b1;
                  seg   <= 3'h0;
                  pos   <= 17'h00000;
                  sent  <= 17'h00000;
                  state <= srts_pkg::ST_PICK;
               end
            end
            srts_pkg::ST_PICK: begin
               if (pos >= seg_len) begin
                  pos <= 17'h00000;
                  if (seg == 3'h7) begin
                     state <= srts_pkg::ST_DONE;
                  end else begin
                     seg <= seg + 3'h1;
                  end
               end else if (in_hole || seg_addr >= size_w) begin
                  pos <= pos + 17'h00001;
               end else begin
                  rd_req  <= 1'b1;
                  rd_type <= cur_t;
                  rd_addr <= seg_addr[15:0];
                  state   <= srts_pkg::ST_WAIT;
               end
            end
            srts_pkg::ST_WAIT: begin
               if (rd_valid) begin
                  word  <= rd_data;
                  state <= srts_pkg::ST_SEND;
               end
            end
            srts_pkg::ST_SEND: begin
               if (tx_ready) begin
                  tx_valid <= 1'b1;
                  pos      <= pos + 17'h00001;
                  sent     <= sent + 17'h00001;
                  state    <= srts_pkg::ST_PICK;
               end
            end
            srts_pkg::ST_DONE: begin
               busy      <= 1'b0;
               scan_done <= 1'b1;
               sent_last <= sent;
               state     <= srts_pkg::ST_IDLE;
            end
            default: state <= srts_pkg::ST_IDLE;
         endcase
      end
   end

   // chunk rotation across scans
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         scan_idx <= 8'h00;
         for (int t = 0; t < 4; t++) begin
            chunk_off[t] <= 17'h00000;
         end
      end else if (ce) begin
         if (ctrl_mode != srts_pkg::MODE_MULTI) begin
            scan_idx <= 8'h00;
            for (int t = 0; t < 4; t++) begin
               chunk_off[t] <= 17'h00000;
            end
         end else if (state == srts_pkg::ST_DONE) begin
            if (scan_idx + 8'h01 >= scans) begin
               scan_idx <= 8'h00;
               for (int t = 0; t < 4; t++) begin
                  chunk_off[t] <= 17'h00000;
               end
            end else begin
               scan_idx <= scan_idx + 8'h01;
               for (int t = 0; t < 4; t++) begin
                  chunk_off[t] <= chunk_off[t] + chunk_w[t];
               end
            end
         end
      end
   end

   // type of the last read in this scan, for order checking
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         last_type <= 2'h0;
      end else if (ce) begin
         if (state == srts_pkg::ST_IDLE) begin
            last_type <= 2'h0;
         end else if (rd_req) begin
            last_type <= rd_type;
         end
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   property p_type_order;
      rd_req |-> rd_type >= last_type;
   endproperty
   a_type_order: assert property (p_type_order) else $error("type order broken");

   property p_default_coil;
      ctrl_mode == srts_pkg::MODE_DEFAULT |->
         every_w[0] == srts_pkg::srts_words(2'h0, srts_pkg::srts_min(size[0], 17'h02000));
   endproperty
   a_default_coil: assert property (p_default_coil) else $error("coil default wrong");

   property p_default_disc;
      ctrl_mode == srts_pkg::MODE_DEFAULT |-> every_w[1] <= 17'h00200;
   endproperty
   a_default_disc: assert property (p_default_disc) else $error("disc default wrong");

   property p_budget;
      ctrl_mode == srts_pkg::MODE_DEFAULT && size[2] >= 17'h02710 && size[3] >= 17'h02710
         |-> every_w[2] == 17'h003E8 && every_w[3] == 17'h02330;
   endproperty
   a_budget: assert property (p_budget) else $error("default budget wrong");

   property p_hold_round;
      ctrl_mode == srts_pkg::MODE_DEFAULT && every_w[3] != size[3] |-> every_w[3][3:0] == 4'h0;
   endproperty
   a_hold_round: assert property (p_hold_round) else $error("holding count not rounded");

   property p_limit;
      rd_req |-> {1'b0, rd_addr} < srts_pkg::srts_words(rd_type, size[rd_type]);
   endproperty
   a_limit: assert property (p_limit) else $error("read above limit");

   property p_hole;
      rd_req && hole_len != 17'h00000 && rd_type == hole_type
         |-> rd_addr < hole_start || {1'b0, rd_addr} >= {1'b0, hole_start} + hole_len;
   endproperty
   a_hole: assert property (p_hole) else $error("hole reference read");

   property p_start;
      state == srts_pkg::ST_IDLE && scan_start && ctrl_en && ce |=> busy ##1 !scan_done;
   endproperty
   a_start: assert property (p_start) else $error("scan not started");

   property p_wrap;
      ce && ctrl_mode == srts_pkg::MODE_MULTI && state == srts_pkg::ST_DONE
         && scan_idx + 8'h01 >= scans |=> scan_idx == 8'h00 && chunk_off[0] == 17'h00000;
   endproperty
   a_wrap: assert property (p_wrap) else $error("chunk did not wrap");

   property p_send;
      tx_valid |=> !tx_ready [*2];
   endproperty
   a_send: assert property (p_send) else $error("link did not take word");
endmodule

// file: core/srts_txser.sv
/*
 * Serial link transmitter: one 16-bit word per frame, start bit, LSB first, stop bit.
 * Assumes the line idles high and the peer samples at the link baud rate.
 */
`timescale 1ns/10ps
module srts_txser (
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic        ce,
   input  wire logic        tx_valid,
   input  wire logic [15:0] tx_word,
   output logic             tx_ready,
   output logic             link_tx
);
   logic [17:0] shift;
   logic [4:0]  bits_left;
   logic [7:0]  baud_cnt;

   // frame shifter paced by the baud counter
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         shift     <= 18'h3FFFF;
         bits_left <= 5'h00;
         baud_cnt  <= 8'h00;
         tx_ready  <= 1'b1;
         link_tx   <= 1'b1;
      end else if (ce) begin
         if (tx_valid && tx_ready) begin
            shift     <= {1'b1, tx_word, 1'b0};
            bits_left <= srts_pkg::FRAME_BITS;
            baud_cnt  <= 8'h00;
            tx_ready  <= 1'b0;
         end else if (bits_left != 5'h00) begin
            if (baud_cnt == 8'h00) begin
               link_tx   <= shift[0];
               shift     <= {1'b1, shift[17:1]};
               bits_left <= bits_left - 5'h01;
               baud_cnt  <= 8'(srts_pkg::BIT_CYC - 1);
            end else begin
               baud_cnt <= baud_cnt - 8'h01;
            end
         end else if (baud_cnt != 8'h00) begin
            baud_cnt <= baud_cnt - 8'h01;               // hold the stop bit a full period
         end else begin
            tx_ready <= 1'b1;
         end
      end
   end
endmodule

// file: shared/srts_pkg.sv
/*
 * Constants, types and helper arithmetic for the state RAM transfer scheduler.
 * Assumes a single 125 MHz clock domain and word-addressed state memory per type.
 */
// How it works
// - each scan sends coils, then discrete inputs, input registers, holding registers
// - default mode copies the lowest 8192 coil points each scan
// - default mode copies the lowest 8192 discrete input points each scan
// - default register budget is 10K words: 1K input, 9K holding
// - unused share of one register type goes to the other type
// - default holding count rounds up to sixteen unless all are included
// - references above the computed limits are never copied
// - references in the non-transfer hole are skipped
// - custom mode takes each type contiguously from its lowest reference
// - modes: custom counts, whole memory, every-scan set plus multi-scan chunks
// - whole-memory mode sends every configured reference outside the hole each scan
// - area ranges from sixteen holding registers up to whole state memory
// - extra region starts right after the every-scan region, multiple of sixteen
// - extra region is split into equal chunks, one chunk per scan
// - selected data streams to the peer over the 10 megabaud serial link
// - transfer starts by requesting data from the controller at scan start
package srts_pkg;
   localparam int CNT_W  = 17;
   localparam int ADDR_W = 16;

   // mode field encodings
   localparam logic [1:0] MODE_DEFAULT = 2'h0;
   localparam logic [1:0] MODE_CUSTOM  = 2'h1;
   localparam logic [1:0] MODE_WHOLE   = 2'h2;
   localparam logic [1:0] MODE_MULTI   = 2'h3;

   // reference types in transfer order
   localparam logic [1:0] TYPE_COIL = 2'h0;
   localparam logic [1:0] TYPE_DISC = 2'h1;
   localparam logic [1:0] TYPE_INRG = 2'h2;
   localparam logic [1:0] TYPE_HOLD = 2'h3;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL       = 8'h00;
   localparam logic [7:0] OFS_SCANS      = 8'h04;
   localparam logic [7:0] OFS_HOLE_TYPE  = 8'h08;
   localparam logic [7:0] OFS_HOLE_START = 8'h0C;
   localparam logic [3:0] GRP_SIZE       = 4'h1;
   localparam logic [3:0] GRP_CUST       = 4'h2;
   localparam logic [3:0] GRP_EXTRA      = 4'h3;
   localparam logic [7:0] OFS_HOLE_LEN   = 8'h40;
   localparam logic [7:0] OFS_STATUS     = 8'h44;
   localparam logic [7:0] OFS_SENT       = 8'h48;

   // control field positions and reset values
   localparam int         CTRL_MODE_LSB = 0;
   localparam int         CTRL_EN_BIT   = 2;
   localparam logic [7:0] RST_SCANS     = 8'h01;
   localparam logic [16:0] RST_COUNT    = 17'h00000;

   // default transfer area
   localparam logic [16:0] DEF_POINTS     = 17'h02000;
   localparam logic [16:0] DEF_IN_SHARE   = 17'h003E8;
   localparam logic [16:0] DEF_HOLD_SHARE = 17'h02328;

   // link timing
   localparam int         CLK_HZ     = 125000000;
   localparam int         LINK_BAUD  = 10000000;
   localparam int         BIT_CYC    = CLK_HZ / LINK_BAUD;
   localparam logic [4:0] FRAME_BITS = 5'h12;

   typedef logic [CNT_W-1:0] srts_cnt_t;
   typedef enum logic [2:0] {ST_IDLE, ST_PICK, ST_WAIT, ST_SEND, ST_DONE} srts_state_e;

   function automatic srts_cnt_t srts_min(input srts_cnt_t a, input srts_cnt_t b);
      srts_min = (a < b) ? a : b;
   endfunction

   function automatic srts_cnt_t srts_up16(input srts_cnt_t a);
      srts_up16 = (a + 17'h0000F) & 17'h1FFF0;
   endfunction

   // bit types pack sixteen points per word
   function automatic srts_cnt_t srts_words(input logic [1:0] t, input srts_cnt_t n);
      srts_words = t[1] ? n : {4'h0, n[16:4]};
   endfunction
endpackage

// file: test/srts_mem_model.sv
/*
 * Controller state memory model: answers each read request after a short or
 * a longer wait and tallies per-type reads for the bench; also plays the peer
 * end of the serial link and matches every frame to the answered words.
 * Assumes one read outstanding and scan_start marking the start of a scan.
 */
`timescale 1ns/10ps
module srts_mem_model (
   input  wire logic        mclk,
   input  wire logic        scan_start,
   input  wire logic        link_tx,
   input  wire logic        rd_req,
   input  wire logic [1:0]  rd_type,
   input  wire logic [15:0] rd_addr,
   output logic             rd_valid,
   output logic [15:0]      rd_data,
   output logic [15:0]      cnt [4],
   output logic [15:0]      top [4],
   output logic [15:0]      bad,
   output logic [15:0]      rx_cnt,
   output logic [15:0]      rx_bad
);
   logic [15:0] ans [16];
   logic [3:0]  wi;
   logic [3:0]  ri;
   logic [15:0] rx_word;
   logic [1:0] wait_c;
   logic       slow;
   logic [1:0] prev;

   // answer reads, alternating prompt and slow replies
   initial begin
      rd_valid = 1'b0;
      rd_data = 16'hA5A5;
      wait_c = 2'h0;
      slow = 1'b0;
      prev = 2'h0;
      bad = 16'h0000;
      wi = 4'h0;
      foreach (cnt[i]) begin
         cnt[i] = 16'h0000;
         top[i] = 16'h0000;
      end
   end
   always @(posedge mclk) begin
      rd_valid <= 1'b0;
      if (!rd_valid)
         rd_data <= ~rd_data; // no stale data between answers
      if (scan_start) begin
         prev <= 2'h0;
         foreach (cnt[i]) begin
            cnt[i] <= 16'h0000;
         end
      end
      if (rd_req) begin
         if (rd_type < prev)
            bad <= bad + 16'h0001;
         prev <= rd_type;
         cnt[rd_type] <= cnt[rd_type] + 16'h0001;
         top[rd_type] <= rd_addr;
         wait_c <= slow ? 2'h3 : 2'h1;
         slow <= !slow;
      end else if (wait_c == 2'h1) begin
         rd_valid <= 1'b1;
         rd_data <= {rd_type, rd_addr[13:0]};
         ans[wi] <= {rd_type, rd_addr[13:0]};
         wi <= wi + 4'h1;
         wait_c <= 2'h0;
      end else if (wait_c != 2'h0)
         wait_c <= wait_c - 2'h1;
   end

   // peer end: sample each frame mid-bit, check stop bit and data in answer order
   initial begin
      rx_cnt = 16'h0000;
      rx_bad = 16'h0000;
      ri = 4'h0;
      rx_word = 16'h0000;
      forever begin
         @(negedge link_tx);
         repeat (srts_pkg::BIT_CYC / 2) @(posedge mclk);
         for (int b = 0; b < 16; b++) begin
            repeat (srts_pkg::BIT_CYC) @(posedge mclk);
            rx_word[b] = link_tx;
         end
         repeat (srts_pkg::BIT_CYC) @(posedge mclk);
         if (link_tx !== 1'b1 || rx_word !== ans[ri])
            rx_bad = rx_bad + 16'h0001;
         ri = ri + 4'h1;
         rx_cnt = rx_cnt + 16'h0001;
      end
   end
endmodule

// file: test/testbench.sv
/*
 * Self-checking bench for the transfer scheduler: register access over
 * AHB-Lite and one scan per mode (three in multi-scan mode), read tallies taken from the memory model.
 * Assumes zero-wait bus slave and the memory model in its own file.
 */
`timescale 1ns/10ps
module testbench;
   logic        mclk = 0, sys_rst = 1, scan_start = 0, hwrite = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, v;
   logic [1:0]  htrans = 0, rd_type;
   logic        hreadyout, hresp, rd_req, rd_valid, busy, scan_done, link_tx;
   logic [15:0] rd_addr, rd_data, bad, rx_cnt, rx_bad;
   int          frames = 0;
   logic [15:0] cnt [4];
   logic [15:0] top [4];
   int          num_errors = 0, n_compared = 0;

   // clock and design under test
   always #4 mclk = ~mclk;
   srts_top u_srts_top (.mclk(mclk), .sys_rst(sys_rst), .ce(1'b1), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .scan_start(scan_start), .rd_req(rd_req), .rd_type(rd_type), .rd_addr(rd_addr),
      .rd_valid(rd_valid), .rd_data(rd_data), .link_tx(link_tx), .busy(busy),
      .scan_done(scan_done));
   srts_mem_model u_srts_mem_model (.mclk(mclk), .scan_start(scan_start),
      .rd_req(rd_req), .rd_type(rd_type), .rd_addr(rd_addr), .rd_valid(rd_valid),
      .rd_data(rd_data), .cnt(cnt), .top(top), .bad(bad), .link_tx(link_tx),
      .rx_cnt(rx_cnt), .rx_bad(rx_bad));

   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s exp %0h got %0h", what, exp, got);
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      v = hrdata;
   endtask

   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(what, exp, v);
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask

   task automatic cfg(input logic [3:0] g, input logic [31:0] c0, c1, c2, c3);
      bus(1'b1, {g, 4'h0}, c0);
      bus(1'b1, {g, 4'h4}, c1);
      bus(1'b1, {g, 4'h8}, c2);
      bus(1'b1, {g, 4'hC}, c3);
   endtask

   task automatic scan(input logic [31:0] e0, e1, e2, e3, t3, sent);
      int k;
      scan_start <= 1'b1;
      @(posedge mclk);
      scan_start <= 1'b0;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (scan_done !== 1'b1 && k < 40000);
      chk("scan done", 32'h1, {31'h0, scan_done});
      // let the last frame finish on the link
      repeat (240) @(posedge mclk);
      frames = frames + int'(sent);
      chk("coil words", e0, 32'(cnt[0]));
      chk("disc words", e1, 32'(cnt[1]));
      chk("inreg words", e2, 32'(cnt[2]));
      chk("hold words", e3, 32'(cnt[3]));
      chk("hold top", t3, 32'(top[3]));
      chk("order faults", 32'h0, 32'(bad));
      chk("frames", frames, 32'(rx_cnt));
      chk("link data", 32'h0, 32'(rx_bad));
      rdchk("sent", srts_pkg::OFS_SENT, sent);
   endtask

   // watchdog against a hung handshake
   initial begin
      #(8 * 100000);
      num_errors++;
      conclude();
   end

   // main sequence
   initial begin
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      rdchk("ctrl", srts_pkg::OFS_CTRL, 32'h0);
      rdchk("scans", srts_pkg::OFS_SCANS, 32'h1);
      rdchk("unmapped", 8'h50, 32'h0);
      scan_start <= 1'b1;
      @(posedge mclk);
      scan_start <= 1'b0;
      repeat (3) @(posedge mclk);
      chk("busy off", 32'h0, {31'h0, busy});
      cfg(srts_pkg::GRP_SIZE, 32'h20, 32'h20, 32'h20, 32'h20);
      cfg(srts_pkg::GRP_CUST, 32'h20, 32'h10, 32'h0, 32'h10);
      bus(1'b1, srts_pkg::OFS_CTRL, 32'h5);
      rdchk("ctrl", srts_pkg::OFS_CTRL, 32'h5);
      scan(2, 1, 0, 16, 15, 19);
      bus(1'b1, srts_pkg::OFS_HOLE_TYPE, 32'h3);
      bus(1'b1, srts_pkg::OFS_HOLE_START, 32'h8);
      bus(1'b1, srts_pkg::OFS_HOLE_LEN, 32'h4);
      bus(1'b1, srts_pkg::OFS_CTRL, 32'h6);
      scan(2, 2, 32, 28, 31, 64);
      bus(1'b1, srts_pkg::OFS_HOLE_LEN, 32'h0);
      cfg(srts_pkg::GRP_EXTRA, 32'h0, 32'h0, 32'h0, 32'h10);
      bus(1'b1, srts_pkg::OFS_SCANS, 32'h2);
      bus(1'b1, srts_pkg::OFS_CTRL, 32'h7);
      scan(2, 1, 0, 24, 23, 27);
      rdchk("status", srts_pkg::OFS_STATUS, 32'h1E);
      scan(2, 1, 0, 24, 31, 27);
      scan(2, 1, 0, 24, 23, 27);
      bus(1'b1, {srts_pkg::GRP_SIZE, 4'hC}, 32'd20);
      bus(1'b1, srts_pkg::OFS_CTRL, 32'h4);
      scan(2, 2, 32, 20, 19, 56);
      conclude();
   end
endmodule
